//--- core/exc_seq_regs.svh
`ifndef EXC_SEQ_REGS_SVH
`define EXC_SEQ_REGS_SVH

// Register word indices on the Avalon-MM slave
`define REG_MSTATE      3'h0
`define REG_SAVED_PC    3'h1
`define REG_SAVED_MS    3'h2
`define REG_STATUS      3'h3
`define REG_RESUME      3'h4

// Machine state field positions
`define MS_EE           0
`define MS_SUP          1
`define MS_FE0          2
`define MS_FE1          3
`define MS_ME           4
`define MS_W            5

// Machine state after reset: supervisor, everything masked
`define MS_RST          5'h02

// Vector offsets
`define VEC_RESET       20'h00100
`define VEC_MCHK        20'h00200

// Default offsets for vectors not fixed here
`define VEC_FP_DFLT     20'h01000
`define VEC_EXT_DFLT    20'h01100
`define VEC_SMI_DFLT    20'h01200
`define VEC_DEC_DFLT    20'h01300

// Pin vector positions
`define PIN_SRESET      0
`define PIN_HRESET      1
`define PIN_MCHK        2
`define PIN_TEA         3
`define PIN_EXT         4
`define PIN_SMI         5
`define PIN_N           6

// Async maskable request positions, lowest index wins
`define ASY_SMI         0
`define ASY_EXT         1
`define ASY_DEC         2
`define ASY_N           3

`endif

//--- core/exc_seq_pkg.sv
package exc_seq_pkg;

  typedef logic [31:0] pc_t;
  typedef logic [19:0] vec_t;
  typedef logic [4:0]  mstate_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRAIN,
    ST_STOP
  } seq_state_e;

  typedef struct packed {
    seq_state_e  state;
    mstate_t     ms;
    pc_t         saved_pc;
    mstate_t     saved_ms;
    logic [2:0]  async_src;
    logic        redirect;
    pc_t         fetch_pc;
    logic        flush;
    logic        bus_ack;
    logic [31:0] rdata;
    logic        rst_q;
    logic        mchk_q;
  } seq_s;

endpackage

//--- core/pin_sync3.sv
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,   // Core clock
  input  wire logic             sys_rst_in,    // Sync reset, high
  input  wire logic             ce_in,         // Clock enable
  input  wire logic [WIDTH-1:0] async_in,      // Raw pin levels
  output logic      [WIDTH-1:0] stable_out     // Agreed levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stab;
  } sync_s;

  sync_s            r;
  sync_s            n;
  logic [WIDTH-1:0] next_stab;

  always_comb begin
    n      = r;
    n.s1   = async_in;
    n.s2   = r.s1;
    n.s3   = r.s2;
    n.stab = next_stab;
  end

  // Level accepted only once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign next_stab[i]  = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.stab[i];
    assign stable_out[i] = r.stab[i];
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

endmodule

//--- core/prio_pick.sv
`timescale 1ns/10ps
module prio_pick #(
  parameter int N = 3
) (
  input  wire logic [N-1:0] req_in,     // Requests
  output logic      [N-1:0] grant_out,  // One-hot, lowest index wins
  output logic              any_out     // Some request present
);

  logic [N:0] blocked;

  assign blocked[0] = 1'b0;

  for (genvar i = 0; i < N; i++) begin : g_pick
    assign grant_out[i]  = req_in[i] & ~blocked[i];
    assign blocked[i+1]  = blocked[i] | req_in[i];
  end

  assign any_out = blocked[N];

endmodule

//--- core/exception_sequencer.sv
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`include "exc_seq_regs.svh"
// Contract
// RULE_01 - Take exceptions strictly in program order
// RULE_02 - Older instructions finish before synchronous exception
// RULE_03 - Older draining exceptions serviced before younger
// RULE_04 - Async precise: drain, save next PC
// RULE_05 - One exception at a time, except resets
// RULE_06 - Save state, supervisor, fetch fixed vector
// RULE_07 - Multiple conditions presented as separate exceptions
// RULE_08 - Instruction exceptions taken precisely
// RULE_09 - Recoverable imprecise FP mode acts precise
// RULE_10 - FP mode 00: full rate, no exception
// RULE_11 - FP bit0 set: precise FP exception
// RULE_12 - FP mode 01: resume PC may pass
// RULE_13 - External interrupt pin: async maskable
// RULE_14 - System management pin: async maskable
// RULE_15 - Decrementer is async maskable too
// RULE_16 - Async waits for in-flight instructions, exceptions
// RULE_17 - Async recognized at once unless masked
// RULE_18 - Reset, machine check nonmaskable, may preempt
// RULE_19 - Soft or hard reset takes reset vector
// RULE_20 - Machine check or checkstop; enable cleared
// RULE_21 - Reset over machine check over others
// RULE_22 - Copy old machine state before altering
module exception_sequencer
  import exc_seq_pkg::*;
#(
  parameter logic [11:0]     VEC_PREFIX = 12'h000,          // Upper vector address bits
  parameter exc_seq_pkg::vec_t VEC_FP   = `VEC_FP_DFLT,     // Floating-point vector
  parameter exc_seq_pkg::vec_t VEC_EXT  = `VEC_EXT_DFLT,    // External interrupt vector
  parameter exc_seq_pkg::vec_t VEC_SMI  = `VEC_SMI_DFLT,    // Sysmgmt interrupt vector
  parameter exc_seq_pkg::vec_t VEC_DEC  = `VEC_DEC_DFLT     // Decrementer vector
) (
  input  wire logic                core_clk_in,             // Core clock
  input  wire logic                sys_rst_in,              // Sync reset, high
  input  wire logic                ce_in,                   // Clock enable
  // Completion side
  input  wire logic                head_valid_in,           // Oldest entry valid
  input  wire exc_seq_pkg::pc_t    head_pc_in,              // Oldest entry address
  input  wire logic                head_exc_in,             // Oldest entry faulted
  input  wire exc_seq_pkg::vec_t   head_exc_vec_in,         // Its vector offset
  input  wire logic                head_fp_exc_in,          // Oldest entry FP fault
  input  wire logic                fp_imprecise_exc_in,     // FP fault, imprecise mode
  input  wire logic                rob_empty_in,            // Nothing in flight
  input  wire exc_seq_pkg::pc_t    resume_pc_in,            // Next sequential address
  input  wire logic                dec_irq_in,              // Decrementer request
  // Pins
  input  wire logic                soft_reset_in,           // Soft reset pin
  input  wire logic                hard_reset_in,           // Hard reset pin
  input  wire logic                mchk_in,                 // Machine-check pin
  input  wire logic                transfer_error_ack_n_in, // Bus error pin, low
  input  wire logic                ext_irq_in,              // External interrupt pin
  input  wire logic                sysmgmt_irq_in,          // Sysmgmt interrupt pin
  // Outputs to fetch, dispatch, float unit
  output logic                     fetch_redirect_out,      // Fetch redirect pulse
  output exc_seq_pkg::pc_t         fetch_pc_out,            // Redirect target
  output logic                     flush_out,               // Exception taken pulse
  output logic                     dispatch_hold_out,       // Stop dispatch
  output logic                     fp_ignore_out,           // Float unit full rate
  output logic                     fp_serialize_out,        // Float unit precise
  output logic                     supervisor_out,          // Supervisor mode
  output logic                     checkstop_out,           // Checkstop state
  // Avalon-MM slave
  input  wire logic [2:0]          avs_address_in,          // Word index
  input  wire logic                avs_read_in,             // Read
  input  wire logic                avs_write_in,            // Write
  input  wire logic [31:0]         avs_writedata_in,        // Write data
  output logic [31:0]              avs_readdata_out,        // Read data
  output logic                     avs_waitrequest_out      // Wait request
);

  seq_s r;
  seq_s n;

  logic [`PIN_N-1:0] pins;
  logic [`ASY_N-1:0] async_req;
  logic [`ASY_N-1:0] async_grant;
  logic              async_any;
  logic              rst_lvl;
  logic              mchk_lvl;
  logic              rst_edge;
  logic              mchk_edge;
  logic              take;
  logic              take_async;
  logic              bus_req;
  logic              wr_commit;
  logic [1:0]        fp_mode;
  vec_t              vec;
  vec_t              async_vec;
  pc_t               spc;
  logic [31:0]       rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  pin_sync3 #(
    .WIDTH (`PIN_N)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .async_in    ({sysmgmt_irq_in, ext_irq_in, ~transfer_error_ack_n_in,
                   mchk_in, hard_reset_in, soft_reset_in}),
    .stable_out  (pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // Async maskable selection

  assign async_req[`ASY_SMI] = pins[`PIN_SMI] & r.ms[`MS_EE];  // RULE_14
  assign async_req[`ASY_EXT] = pins[`PIN_EXT] & r.ms[`MS_EE];  // RULE_13
  assign async_req[`ASY_DEC] = dec_irq_in & r.ms[`MS_EE];      // RULE_15

  prio_pick #(
    .N (`ASY_N)
  ) u_pick (
    .req_in    (async_req),
    .grant_out (async_grant),
    .any_out   (async_any)
  );

  always_comb begin
    async_vec = VEC_DEC;
    if (r.async_src[`ASY_SMI]) begin
      async_vec = VEC_SMI;
    end else if (r.async_src[`ASY_EXT]) begin
      async_vec = VEC_EXT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      `REG_MSTATE:   rd_mux = {27'h0, r.ms};
      `REG_SAVED_PC: rd_mux = r.saved_pc;
      `REG_SAVED_MS: rd_mux = {27'h0, r.saved_ms};
      `REG_STATUS:   rd_mux = {27'h0, r.async_src, r.state == ST_DRAIN, r.state == ST_STOP};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  assign rst_lvl    = pins[`PIN_SRESET] | pins[`PIN_HRESET];
  assign mchk_lvl   = pins[`PIN_MCHK] | pins[`PIN_TEA];
  assign rst_edge   = rst_lvl & ~r.rst_q;
  assign mchk_edge  = mchk_lvl & ~r.mchk_q;
  assign fp_mode    = {r.ms[`MS_FE1], r.ms[`MS_FE0]};
  assign bus_req    = avs_read_in | avs_write_in;
  assign wr_commit  = avs_write_in & r.bus_ack;

  always_comb begin
    n          = r;
    n.redirect = 1'b0;
    n.flush    = 1'b0;
    n.rst_q    = rst_lvl;
    n.mchk_q   = mchk_lvl;
    n.bus_ack  = bus_req & ~r.bus_ack;
    if (bus_req & ~r.bus_ack) begin
      n.rdata = rd_mux;
    end
    if (wr_commit) begin
      unique case (avs_address_in)
        `REG_MSTATE:   n.ms       = avs_writedata_in[`MS_W-1:0];
        `REG_SAVED_PC: n.saved_pc = avs_writedata_in;
        `REG_SAVED_MS: n.saved_ms = avs_writedata_in[`MS_W-1:0];
        `REG_RESUME: begin
          n.ms       = r.saved_ms;
          n.redirect = 1'b1;
          n.fetch_pc = r.saved_pc;
        end
        default: begin
        end
      endcase
    end

    take       = 1'b0;
    take_async = 1'b0;
    vec        = `VEC_RESET;
    spc        = head_pc_in;
    if (rst_edge) begin                                        // RULE_19
      take = 1'b1;                                             // RULE_21
      vec  = `VEC_RESET;                                       // RULE_18
    end else if (r.state == ST_STOP) begin
      take = 1'b0;
    end else if (mchk_edge) begin
      if (r.ms[`MS_ME]) begin                                  // RULE_20
        take = 1'b1;
        vec  = `VEC_MCHK;
      end else begin
        n.state = ST_STOP;
      end
    end else if (head_valid_in & head_exc_in) begin            // RULE_02 RULE_03
      take = 1'b1;                                             // RULE_08
      vec  = head_exc_vec_in;
    end else if (head_valid_in & head_fp_exc_in & r.ms[`MS_FE0]) begin  // RULE_11
      take = 1'b1;                                             // RULE_09
      vec  = VEC_FP;
    end else if (fp_mode == 2'b10 && fp_imprecise_exc_in) begin // RULE_12
      take = 1'b1;
      vec  = VEC_FP;
    end else if (r.state == ST_DRAIN && rob_empty_in) begin    // RULE_16
      take       = 1'b1;                                       // RULE_04
      take_async = 1'b1;
      vec        = async_vec;
      spc        = resume_pc_in;
    end else if (r.state == ST_RUN && async_any) begin         // RULE_17
      n.state     = ST_DRAIN;
      n.async_src = async_grant;
    end

    if (take) begin                                            // RULE_05
      n.saved_pc         = spc;
      n.saved_ms         = r.ms;                               // RULE_22
      n.ms[`MS_EE]       = 1'b0;
      n.ms[`MS_SUP]      = 1'b1;                               // RULE_06
      n.ms[`MS_ME]       = 1'b0;                               // RULE_20
      n.redirect         = 1'b1;
      n.fetch_pc         = {VEC_PREFIX, vec};
      n.flush            = 1'b1;                               // RULE_07
      n.state            = ST_RUN;
      n.async_src        = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      r <= '{state: ST_RUN, ms: `MS_RST, default: '0};
    end else if (ce_in) begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign fetch_redirect_out  = r.redirect;
  assign fetch_pc_out        = r.fetch_pc;
  assign flush_out           = r.flush;
  assign dispatch_hold_out   = r.state != ST_RUN;              // RULE_01
  assign fp_ignore_out       = fp_mode == 2'b00;               // RULE_10
  assign fp_serialize_out    = r.ms[`MS_FE0];                  // RULE_11
  assign supervisor_out      = r.ms[`MS_SUP];
  assign checkstop_out       = r.state == ST_STOP;
  assign avs_readdata_out    = r.rdata;
  assign avs_waitrequest_out = bus_req & ~r.bus_ack;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  reset_vector_a: assert property (  // RULE_19
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && rst_edge) |=> (fetch_redirect_out && flush_out
                             && fetch_pc_out == {VEC_PREFIX, `VEC_RESET}))
    else $error("reset vector not taken");

  mchk_checkstop_a: assert property (  // RULE_20
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && mchk_edge && !rst_edge && !r.ms[`MS_ME] && r.state != ST_STOP)
      |=> (checkstop_out && !flush_out))
    else $error("machine check without enable did not checkstop");

  mchk_vector_a: assert property (  // RULE_21
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && mchk_edge && !rst_edge && r.ms[`MS_ME] && r.state != ST_STOP
     && head_valid_in && head_exc_in)
      |=> (fetch_pc_out == {VEC_PREFIX, `VEC_MCHK}))
    else $error("machine check lost priority");

  take_state_a: assert property (  // RULE_06
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && take) |=> (supervisor_out && !r.ms[`MS_ME] && !r.ms[`MS_EE]
                         && r.saved_ms == $past(r.ms)))
    else $error("machine state not saved or switched");

  precise_pc_a: assert property (  // RULE_08
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && head_valid_in && head_exc_in && !rst_edge && !mchk_edge
     && r.state != ST_STOP)
      |=> (r.saved_pc == $past(head_pc_in)
           && fetch_pc_out == {VEC_PREFIX, $past(head_exc_vec_in)}))
    else $error("instruction exception not precise");

  async_drain_a: assert property (  // RULE_16
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && r.state == ST_DRAIN && !rob_empty_in && !rst_edge && !mchk_edge
     && !head_exc_in && !head_fp_exc_in && !fp_imprecise_exc_in)
      |=> (dispatch_hold_out && !flush_out && $stable(r.async_src)))
    else $error("async taken before drain finished");

  async_mask_a: assert property (  // RULE_17
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && $rose(r.state == ST_DRAIN)) |-> $past(r.ms[`MS_EE]))
    else $error("masked async request recognized");

  async_resume_a: assert property (  // RULE_04
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && take_async) |=> (r.saved_pc == $past(resume_pc_in) && flush_out
                               && dispatch_hold_out == 1'b0))
    else $error("async resume address wrong");

  fp_ignore_a: assert property (  // RULE_10
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && fp_mode == 2'b00 && head_valid_in && head_fp_exc_in && !head_exc_in
     && !rst_edge && !mchk_edge && r.state == ST_RUN && !async_any)
      |=> !flush_out)
    else $error("ignore mode raised an FP exception");

  bus_wait_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && $rose(bus_req)) |-> (avs_waitrequest_out ##1 !avs_waitrequest_out))
    else $error("waitrequest timing wrong");

  read_data_a: assert property (
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (avs_read_in && !avs_waitrequest_out) |-> (avs_readdata_out == $past(rd_mux)))
    else $error("read data not from addressed register");

  imprecise_fp_a: assert property (  // RULE_12
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && fp_mode == 2'b10 && fp_imprecise_exc_in && !rst_edge && !mchk_edge
     && r.state != ST_STOP && !(head_valid_in && head_exc_in))
      |=> (flush_out && fetch_pc_out == {VEC_PREFIX, VEC_FP}))
    else $error("imprecise fp exception not taken");

  stop_hold_a: assert property (  // RULE_18
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && checkstop_out && !rst_edge) |=> (checkstop_out && !flush_out))
    else $error("checkstop left without reset");

  async_recog_a: assert property (  // RULE_13 RULE_14
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (ce_in && r.state == ST_RUN && (pins[`PIN_EXT] || pins[`PIN_SMI]) && r.ms[`MS_EE]
     && !take) |=> dispatch_hold_out)
    else $error("unmasked interrupt not recognized");

endmodule

//--- dv/completion_model.sv
`timescale 1ns/10ps
module completion_model
  import exc_seq_pkg::*;
(
  input  wire logic       core_clk_in,    // Core clock
  input  wire logic       sys_rst_in,     // Sync reset, high
  input  wire logic       flush_in,       // Exception taken
  input  wire logic       load_in,        // Load a new head entry
  input  wire logic [1:0] kind_in,        // 0 none, 1 sync, 2 fp, 3 imprecise fp
  input  wire pc_t        pc_in,          // Head address
  input  wire vec_t       vec_in,         // Head vector
  input  wire logic [7:0] busy_in,        // Cycles until drained
  output logic            head_valid_out, // Oldest entry valid
  output pc_t             head_pc_out,    // Oldest entry address
  output logic            head_exc_out,   // Oldest entry faulted
  output vec_t            head_vec_out,   // Its vector
  output logic            head_fp_out,    // FP fault
  output logic            impr_out,       // Imprecise FP fault
  output logic            rob_empty_out,  // Nothing in flight
  output pc_t             resume_pc_out   // Next sequential address
);
  logic [1:0] kind_q;
  pc_t        pc_q;
  vec_t       vec_q;
  logic [7:0] cnt_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      kind_q <= 2'h0;
      pc_q   <= 32'h0;
      vec_q  <= 20'h0;
      cnt_q  <= 8'h00;
    end else begin
      if (load_in) begin
        kind_q <= kind_in;
        pc_q   <= pc_in;
        vec_q  <= vec_in;
      end else if (flush_in) begin
        kind_q <= 2'h0;  // Faulting entry retires on take
      end
      if (busy_in != 8'h00) begin
        cnt_q <= busy_in;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // Released lines show no stale value
  assign head_valid_out = (kind_q != 2'h0) || (cnt_q != 8'h00);
  assign head_pc_out    = head_valid_out ? pc_q : ~pc_q;
  // Taken entry withdraws its fault in the flush cycle
  assign head_exc_out   = (kind_q == 2'h1) && !flush_in;
  assign head_vec_out   = head_exc_out ? vec_q : ~vec_q;
  assign head_fp_out    = (kind_q == 2'h2) && !flush_in;
  assign impr_out       = (kind_q == 2'h3) && !flush_in;
  assign rob_empty_out  = !head_valid_out;
  assign resume_pc_out  = pc_q + 32'h0000_0004;
endmodule

//--- dv/exception_sequencer_test.sv
`timescale 1ns/10ps
`include "exc_seq_regs.svh"
module exception_sequencer_test;
  import exc_seq_pkg::*;
  logic core_clk, sys_rst, ce, soft_rst, hard_rst, mchk, tea_n, ext_irq, smi_irq, dec_irq;
  logic avs_read, avs_write, load, flush, redir, hold, fp_ign, fp_ser, sup, stop, waitreq;
  logic hv, he, hf, impr, empty;
  logic [2:0]  avs_address;
  logic [1:0]  kind;
  logic [7:0]  busy;
  logic [31:0] avs_writedata, rdata, junk, fp_ms[4];
  pc_t         pc, cur_pc, hpc, rpc, fpc;
  vec_t        vec, hvec, av[3];
  int          num_errors, cmp_count, cyc;

  completion_model model (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .flush_in(flush),
    .load_in(load), .kind_in(kind), .pc_in(pc), .vec_in(vec), .busy_in(busy),
    .head_valid_out(hv), .head_pc_out(hpc), .head_exc_out(he), .head_vec_out(hvec),
    .head_fp_out(hf), .impr_out(impr), .rob_empty_out(empty), .resume_pc_out(rpc));

  exception_sequencer uut (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .ce_in(ce),
    .head_valid_in(hv), .head_pc_in(hpc), .head_exc_in(he), .head_exc_vec_in(hvec),
    .head_fp_exc_in(hf), .fp_imprecise_exc_in(impr), .rob_empty_in(empty),
    .resume_pc_in(rpc), .dec_irq_in(dec_irq), .soft_reset_in(soft_rst),
    .hard_reset_in(hard_rst), .mchk_in(mchk), .transfer_error_ack_n_in(tea_n),
    .ext_irq_in(ext_irq), .sysmgmt_irq_in(smi_irq), .fetch_redirect_out(redir),
    .fetch_pc_out(fpc), .flush_out(flush), .dispatch_hold_out(hold),
    .fp_ignore_out(fp_ign), .fp_serialize_out(fp_ser), .supervisor_out(sup),
    .checkstop_out(stop), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      num_errors++;
    end
  endtask

  // Avalon-MM master: hold until waitrequest is sampled low, take data at that edge
  task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= adr;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk);
    end while (waitreq !== 1'b0);
    rd = rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [2:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, adr, 32'h0, v);
    chk(v, exp, "register read");
  endtask

  task automatic load_head(input logic [1:0] k, input pc_t p, input vec_t v);
    @(posedge core_clk);
    load   <= 1'b1;
    kind   <= k;
    pc     <= p;
    vec    <= v;
    cur_pc = p;
    @(posedge core_clk);
    load <= 1'b0;
  endtask

  task automatic wait_redir(input pc_t exp, input logic fl);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 100 && !seen; n++) begin
      #1;
      if (redir === 1'b1) seen = 1'b1;
      else @(posedge core_clk);
    end
    chk(seen, 1'b1, "no redirect");
    chk(flush, fl, "flush pulse");
    chk(fpc, exp, "fetch target");
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      chk(flush, 1'b0, "unexpected take");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    {sys_rst, ce, tea_n} = 3'b111;
    {soft_rst, hard_rst, mchk, ext_irq, smi_irq, dec_irq, avs_read, avs_write, load} = 9'h0;
    {avs_address, kind, busy, avs_writedata, pc, vec} = 'h0;
    fp_ms = '{32'h02, 32'h06, 32'h0A, 32'h0E};
    av    = '{`VEC_SMI_DFLT, `VEC_EXT_DFLT, `VEC_DEC_DFLT};
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    chk(sup, 1'b1, "supervisor after reset");
    chk(stop, 1'b0, "checkstop after reset");
    rdchk(`REG_MSTATE, 32'h02);
    rdchk(3'h5, 32'h0);
    // Synchronous fault, resume, second condition of same instruction
    bus(1'b1, `REG_MSTATE, 32'h11, junk);
    chk(sup, 1'b0, "user mode");
    load_head(2'h1, 32'h0000_4A40, 20'h00700);
    wait_redir({12'h000, 20'h00700}, 1'b1);
    chk(sup, 1'b1, "supervisor on take");
    rdchk(`REG_SAVED_PC, 32'h0000_4A40);
    rdchk(`REG_SAVED_MS, 32'h11);
    rdchk(`REG_MSTATE, 32'h02);
    bus(1'b1, `REG_RESUME, 32'h0, junk);
    wait_redir(32'h0000_4A40, 1'b0);
    rdchk(`REG_MSTATE, 32'h11);
    load_head(2'h1, 32'h0000_4A40, 20'h00600);
    wait_redir({12'h000, 20'h00600}, 1'b1);
    // Floating-point modes
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `REG_MSTATE, fp_ms[i], junk);
      chk(fp_ign, i == 0, "fp ignore");
      chk(fp_ser, i[0], "fp serialize");
      load_head((i == 2) ? 2'h3 : 2'h2, 32'h0000_5000 + 32'(i * 16), 20'h0);
      if (i == 0) begin
        idle(30);
        load_head(2'h0, cur_pc, 20'h0);
      end else begin
        wait_redir({12'h000, `VEC_FP_DFLT}, 1'b1);
      end
      if (i == 2) rdchk(`REG_SAVED_PC, 32'h0000_5020);
    end
    // Masked interrupt is not recognised
    @(posedge core_clk) ext_irq <= 1'b1;
    idle(12);
    chk(hold, 1'b0, "masked hold");
    @(posedge core_clk) ext_irq <= 1'b0;
    idle(6);
    // Each maskable source waits for the drain
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      busy    <= 8'h1E;
      smi_irq <= (k == 0);
      ext_irq <= (k == 1);
      dec_irq <= (k == 2);
      @(posedge core_clk) busy <= 8'h00;
      repeat (6) @(posedge core_clk);
      bus(1'b1, `REG_MSTATE, 32'h03, junk);
      repeat (4) @(posedge core_clk);
      #1;
      chk(hold, 1'b1, "drain hold");
      rdchk(`REG_STATUS, 32'h2 | (32'h4 << k));
      if (k == 1) begin
        load_head(2'h1, 32'h0000_6000, 20'h00700);
        wait_redir({12'h000, 20'h00700}, 1'b1);
        bus(1'b1, `REG_MSTATE, 32'h03, junk);
      end
      wait_redir({12'h000, av[k]}, 1'b1);
      chk(empty, 1'b1, "taken before drain");
      @(posedge core_clk) {smi_irq, ext_irq, dec_irq} <= 3'h0;
      rdchk(`REG_SAVED_PC, cur_pc + 32'h4);
      repeat (6) @(posedge core_clk);
    end
    // Machine check, priority, checkstop, resets
    bus(1'b1, `REG_MSTATE, 32'h12, junk);
    @(posedge core_clk) mchk <= 1'b1;
    wait_redir({12'h000, `VEC_MCHK}, 1'b1);
    @(posedge core_clk) mchk <= 1'b0;
    rdchk(`REG_MSTATE, 32'h02);
    repeat (6) @(posedge core_clk);
    bus(1'b1, `REG_MSTATE, 32'h12, junk);
    @(posedge core_clk) {soft_rst, mchk} <= 2'b11;
    wait_redir({12'h000, `VEC_RESET}, 1'b1);
    @(posedge core_clk) {soft_rst, mchk} <= 2'b00;
    repeat (8) @(posedge core_clk);
    bus(1'b1, `REG_MSTATE, 32'h02, junk);
    @(posedge core_clk) tea_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(stop, 1'b1, "checkstop");
    chk(hold, 1'b1, "checkstop hold");
    @(posedge core_clk) {tea_n, hard_rst} <= 2'b11;
    wait_redir({12'h000, `VEC_RESET}, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk(stop, 1'b0, "checkstop left");
    @(posedge core_clk) hard_rst <= 1'b0;
    idle(8);
    // Frozen clock enable holds a raised reset pin back
    @(posedge core_clk) {ce, soft_rst} <= 2'b01;
    idle(12);
    @(posedge core_clk) ce <= 1'b1;
    wait_redir({12'h000, `VEC_RESET}, 1'b1);
    @(posedge core_clk) soft_rst <= 1'b0;
    wrap_up();
  end
endmodule
